// *** core/station_address_pkg.sv ***
package station_address_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int           ADDR_W        = 12;
	localparam int           DATA_W        = 32;
	localparam int           STRB_W        = 4;
	localparam int           FIELD_W       = 16;

	// ----------------------------------------------------------------
	// Register offsets: direct word and its clear, set and invert aliases
	// ----------------------------------------------------------------
	localparam logic [11:0]  OFS_DIRECT    = 12'h000;
	localparam logic [11:0]  OFS_CLEAR     = 12'h004;
	localparam logic [11:0]  OFS_SET       = 12'h008;
	localparam logic [11:0]  OFS_INVERT    = 12'h00c;
	localparam logic [11:0]  OFS_SPAN_MASK = 12'hff3;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int           FIRST_LSB     = 0;
	localparam int           FIRST_MSB     = 7;
	localparam int           SECOND_LSB    = 8;
	localparam int           SECOND_MSB    = 15;
	localparam int           RESERVED_LSB  = 16;
	localparam int           RESERVED_MSB  = 31;
	localparam logic [15:0]  RESERVED_READ = 16'h0000;

	// ----------------------------------------------------------------
	// Reset value held only until the factory address is loaded
	// ----------------------------------------------------------------
	localparam logic [15:0]  RESET_VALUE   = 16'h0000;

	// ----------------------------------------------------------------
	// Accepted write strobe patterns: low half, high half, whole word
	// ----------------------------------------------------------------
	localparam logic [3:0]   STRB_LOW      = 4'h3;
	localparam logic [3:0]   STRB_HIGH     = 4'hc;
	localparam logic [3:0]   STRB_WORD     = 4'hf;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_ACK  = 2'b11
	} bus_state_t;

	typedef enum logic [1:0] {
		OP_WRITE  = 2'b00,
		OP_CLEAR  = 2'b01,
		OP_SET    = 2'b10,
		OP_INVERT = 2'b11
	} alias_op_t;

endpackage

// *** core/alias_merge.sv ***
`timescale 1ns/1ps

module alias_merge
	import station_address_pkg::*;
(
	input  wire station_address_pkg::alias_op_t    op,
	input  wire logic [station_address_pkg::FIELD_W-1:0] cur,
	input  wire logic [station_address_pkg::FIELD_W-1:0] wdata,
	input  wire logic [1:0]                        lane_en,
	output logic      [station_address_pkg::FIELD_W-1:0] nxt
);

	import station_address_pkg::*;

	// ----------------------------------------------------------------
	// Per-bit merge of a write into the held value
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < FIELD_W; i = i + 1) begin : g_bit
			always_comb begin
				if (!lane_en[i / 8]) begin
					nxt[i] = cur[i];
				end else begin
					case (op)
						OP_WRITE:  nxt[i] = wdata[i];
						OP_CLEAR:  nxt[i] = cur[i] & ~wdata[i];
						OP_SET:    nxt[i] = cur[i] | wdata[i];
						OP_INVERT: nxt[i] = cur[i] ^ wdata[i];
						default:   nxt[i] = cur[i];
					endcase
				end
			end
		end
	endgenerate

endmodule

// *** core/station_address_word_two.sv ***
`timescale 1ns/1ps

// Summary of operation
// - The word answers at its base offset and at base plus 0x4, 0x8 and 0xC as clear, set and invert aliases.
// - Bits 15 down to 8 hold the second transmitted station address octet, readable and writable.
// - Bits 7 down to 0 hold the first transmitted, most significant station address octet, readable and writable.
// - Bits 31 down to 16 are reserved, software writes zero there, and the block reads them back as zero.
// - Half-word and whole-word writes are taken, while byte-wide writes are dropped without effect.
// - After reset both octets are loaded from the factory-programmed address rather than a fixed constant.
module station_address_word_two
	import station_address_pkg::*;
(
	input  wire logic                                    clk,
	input  wire logic                                    rst_n,
	input  wire logic [station_address_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                                    psel,
	input  wire logic                                    penable,
	input  wire logic                                    pwrite,
	input  wire logic [station_address_pkg::DATA_W-1:0]  pwdata,
	input  wire logic [station_address_pkg::STRB_W-1:0]  pstrb,
	output logic      [station_address_pkg::DATA_W-1:0]  prdata,
	output logic                                         pready,
	output logic                                         pslverr,
	input  wire logic [7:0]                              factory_octet_first,
	input  wire logic [7:0]                              factory_octet_second,
	output logic      [7:0]                              station_octet_first,
	output logic      [7:0]                              station_octet_second
);

	import station_address_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bus_state_t                 state_reg;
	logic [FIELD_W-1:0]         address_reg;
	logic [FIELD_W-1:0]         address_next;
	logic [DATA_W-1:0]          prdata_reg;
	logic                       pready_reg;
	logic                       pslverr_reg;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic                       addr_hit;
	logic                       size_ok;
	logic [1:0]                 lane_en;
	alias_op_t                  op;
	logic                       take;
	logic                       commit;

	assign addr_hit = ((paddr & OFS_SPAN_MASK) == OFS_DIRECT);
	assign op       = alias_op_t'(paddr[3:2]);
	assign size_ok  = (pstrb == STRB_LOW) || (pstrb == STRB_HIGH) || (pstrb == STRB_WORD);
	assign lane_en  = size_ok ? pstrb[1:0] : 2'b00;
	assign take     = (state_reg == ST_IDLE) && psel && penable;
	assign commit   = (state_reg == ST_ACK) && psel && penable && pwrite && addr_hit && size_ok;

	alias_merge u_merge (
		.op      (op),
		.cur     (address_reg),
		.wdata   (pwdata[FIELD_W-1:0]),
		.lane_en (lane_en),
		.nxt     (address_next)
	);

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// The access waits one cycle for the registered ready, which keeps
	// every bus output on a flip-flop at the cost of a wait state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_LOAD;
		end else begin
			case (state_reg)
				ST_LOAD: state_reg <= ST_IDLE;
				ST_IDLE: begin
					if (take) begin
						state_reg <= ST_ACK;
					end
				end
				ST_ACK:  state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= take;
			pslverr_reg <= take && !addr_hit;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= '0;
		end else if (take && !pwrite && addr_hit) begin
			prdata_reg <= {RESERVED_READ, address_reg};
		end else begin
			prdata_reg <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Station address storage
	// ----------------------------------------------------------------
	// Asynchronous reset can only place a constant; the factory value
	// is picked up by the first clock edge after release, and the bus
	// is held off until then so no write can race the load.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			address_reg <= RESET_VALUE;
		end else if (state_reg == ST_LOAD) begin
			address_reg <= {factory_octet_second, factory_octet_first};
		end else if (commit) begin
			address_reg <= address_next;
		end
	end

	assign prdata               = prdata_reg;
	assign pready               = pready_reg;
	assign pslverr              = pslverr_reg;
	assign station_octet_first  = address_reg[FIRST_MSB:FIRST_LSB];
	assign station_octet_second = address_reg[SECOND_MSB:SECOND_LSB];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_clear_alias_effect: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_CLEAR && pstrb == STRB_WORD)
		|=> (address_reg == ($past(address_reg) & ~$past(pwdata[FIELD_W-1:0]))))
		else $error("clear alias did not clear the written ones");

	a_second_octet_write: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_WRITE && pstrb == STRB_WORD)
		|=> (station_octet_second == $past(pwdata[SECOND_MSB:SECOND_LSB])))
		else $error("second octet did not take the written byte");

	a_first_octet_write: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_WRITE && pstrb == STRB_LOW)
		|=> (station_octet_first == $past(pwdata[FIRST_MSB:FIRST_LSB])))
		else $error("first octet did not take the written byte");

	a_reserved_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
		pready_reg |-> (prdata_reg[RESERVED_MSB:RESERVED_LSB] == RESERVED_READ))
		else $error("reserved bits did not read as zero");

	a_byte_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		((state_reg == ST_ACK) && psel && penable && pwrite && !size_ok)
		|=> $stable(address_reg))
		else $error("byte-wide write changed the register");

	a_factory_load_done: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && (state_reg == ST_LOAD))
		|=> (station_octet_first == $past(factory_octet_first))
		&& (station_octet_second == $past(factory_octet_second)) && !pready_reg)
		else $error("factory address not loaded after reset");

	a_invert_alias_toggle: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_INVERT && pstrb == STRB_WORD)
		|=> (address_reg == ($past(address_reg) ^ $past(pwdata[FIELD_W-1:0]))))
		else $error("invert alias did not toggle the written ones");

	a_set_alias_effect: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_SET && pstrb == STRB_LOW)
		|=> (address_reg == ($past(address_reg) | $past(pwdata[FIELD_W-1:0]))))
		else $error("set alias did not set the written ones");

	a_ready_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
		(take ##1 pready_reg) |=> !pready_reg)
		else $error("ready held longer than one cycle");

	// ----------------------------------------------------------------
	// Assertion support
	// ----------------------------------------------------------------
	// Counts access cycles still waiting for ready, so the single wait
	// state can be checked without a long repetition in a property.
	logic [1:0]                 wait_cnt_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt_reg <= 2'b00;
		end else if (psel && penable && !pready_reg) begin
			if (wait_cnt_reg != 2'b11) begin
				wait_cnt_reg <= wait_cnt_reg + 2'b01;
			end
		end else begin
			wait_cnt_reg <= 2'b00;
		end
	end

	// ----------------------------------------------------------------
	// Handshake checks
	// ----------------------------------------------------------------
	a_one_wait_state: assert property (@(posedge clk) disable iff (!rst_n)
		(wait_cnt_reg <= 2'b01))
		else $error("access waited more than one cycle for ready");

	a_ready_after_take: assert property (@(posedge clk) disable iff (!rst_n)
		pready_reg |-> $past(take))
		else $error("ready raised without an accepted access");

	a_error_with_ready: assert property (@(posedge clk) disable iff (!rst_n)
		pslverr_reg |-> pready_reg)
		else $error("error flag raised without ready");

	a_ack_returns_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_ACK) |=> (state_reg == ST_IDLE))
		else $error("answer state lasted more than one cycle");

	a_take_to_ack: assert property (@(posedge clk) disable iff (!rst_n)
		take
		|=> (state_reg == ST_ACK))
		else $error("accepted access did not reach the answer state");

	a_write_data_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(take && pwrite) |=> (prdata_reg == '0))
		else $error("write answer carried read data");

	// ----------------------------------------------------------------
	// Decode checks
	// ----------------------------------------------------------------
	a_alias_offsets_hit: assert property (@(posedge clk) disable iff (!rst_n)
		(take && ((paddr == OFS_CLEAR) || (paddr == OFS_SET) || (paddr == OFS_INVERT)))
		|=> (pready_reg && !pslverr_reg))
		else $error("alias offset was not accepted");

	a_unmapped_error_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(take && !addr_hit)
		|=> (pready_reg && pslverr_reg && (prdata_reg == '0)))
		else $error("unmapped access was not flagged");

	a_unmapped_write_kept: assert property (@(posedge clk) disable iff (!rst_n)
		((state_reg == ST_ACK) && psel && penable && pwrite && !addr_hit)
		|=> $stable(address_reg))
		else $error("unmapped write changed the register");

	a_data_zero_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!pready_reg |-> (prdata_reg == '0))
		else $error("read data not zero outside a read answer");

	// ----------------------------------------------------------------
	// Field and alias checks
	// ----------------------------------------------------------------
	a_second_octet_read: assert property (@(posedge clk) disable iff (!rst_n)
		(take && !pwrite && addr_hit)
		|=> (prdata_reg[SECOND_MSB:SECOND_LSB] == station_octet_second))
		else $error("read did not return the second octet");

	a_first_octet_read: assert property (@(posedge clk) disable iff (!rst_n)
		(take && !pwrite && addr_hit)
		|=> (prdata_reg[FIRST_MSB:FIRST_LSB] == station_octet_first))
		else $error("read did not return the first octet");

	a_second_octet_half: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_WRITE && pstrb == STRB_LOW)
		|=> (station_octet_second == $past(pwdata[SECOND_MSB:SECOND_LSB])))
		else $error("half-word write missed the second octet");

	a_first_octet_word: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_WRITE && pstrb == STRB_WORD)
		|=> (station_octet_first == $past(pwdata[FIRST_MSB:FIRST_LSB])))
		else $error("word write missed the first octet");

	a_high_half_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && pstrb == STRB_HIGH)
		|=> $stable(address_reg))
		else $error("write to the reserved half changed the register");

	a_quiet_keeps_value: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && (state_reg != ST_LOAD) && !commit)
		|=> $stable(address_reg))
		else $error("register changed without a write");

	a_clear_low_half: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_CLEAR && pstrb == STRB_LOW)
		|=> (address_reg == ($past(address_reg) & ~$past(pwdata[FIELD_W-1:0]))))
		else $error("clear alias half-word did not clear the written ones");

	a_set_alias_word: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_SET && pstrb == STRB_WORD)
		|=> (address_reg == ($past(address_reg) | $past(pwdata[FIELD_W-1:0]))))
		else $error("set alias word did not set the written ones");

	a_invert_low_half: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && op == OP_INVERT && pstrb == STRB_LOW)
		|=> (address_reg == ($past(address_reg) ^ $past(pwdata[FIELD_W-1:0]))))
		else $error("invert alias half-word did not toggle the written ones");

	a_load_once: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && (state_reg == ST_LOAD))
		|=> (state_reg == ST_IDLE))
		else $error("factory load did not finish in one cycle");

endmodule

// *** tb/station_address_word_two_tb.sv ***
`timescale 1ns/1ps
module station_address_word_two_tb;
	import station_address_pkg::*;
	logic        clk     = 1'b0;
	logic        rst_n   = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0;
	logic [3:0]  pstrb   = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  fac_first  = 8'h00;
	logic [7:0]  fac_second = 8'h00;
	logic [7:0]  station_octet_first;
	logic [7:0]  station_octet_second;
	logic [31:0] seed = 32'hd7f43074;
	logic [15:0] shadow;
	logic [31:0] rd;
	logic        er;
	logic [3:0]  strb_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'hf, 4'h0};
	logic [11:0] ofs_tab [4];
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          cyc       = 0;

	station_address_word_two i_station_address_word_two (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .factory_octet_first(fac_first), .factory_octet_second(fac_second),
		.station_octet_first(station_octet_first), .station_octet_second(station_octet_second));

	always #10 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ----------------------------------------------------------------
	// Expected register value after one write
	// ----------------------------------------------------------------
	function automatic logic [15:0] model(input logic [11:0] a, input logic [15:0] c, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] m;
		m = (s == 4'h3 || s == 4'hf) ? 16'hffff : 16'h0000;
		case (a)
			12'h000: return (c & ~m) | (d[15:0] & m);
			12'h004: return c & ~(d[15:0] & m);
			12'h008: return c | (d[15:0] & m);
			12'h00c: return c ^ (d[15:0] & m);
			default: return c;
		endcase
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// One APB transfer; the answer is taken at the edge that sees pready.
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check_all();
		apb(1'b0, 12'h000, 32'h0, 4'hf, rd, er);
		chk("readback", rd, {16'h0000, shadow});
		chk("read_err", {31'h0, er}, 32'h0);
		chk("octets", {16'h0, station_octet_second, station_octet_first}, {16'h0, shadow});
	endtask

	// A fresh factory value each time proves the load is not a constant.
	task automatic do_reset();
		seed = lfsr(seed);
		@(posedge clk);
		fac_first  <= seed[7:0];
		fac_second <= seed[15:8];
		rst_n      <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n  <= 1'b1;
		shadow = seed[15:0];
		check_all();
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		ofs_tab = '{12'h000, 12'h004, 12'h008, 12'h00c};
		do_reset();
		for (int i = 0; i < 200; i++) begin
			seed = lfsr(seed);
			apb(1'b1, ofs_tab[seed[17:16]], {16'h0000, seed[15:0]}, strb_tab[seed[20:18]], rd, er);
			chk("write_err", {31'h0, er}, 32'h0);
			shadow = model(ofs_tab[seed[17:16]], shadow, seed, strb_tab[seed[20:18]]);
			if (seed[21])
				check_all();
		end
		check_all();
		apb(1'b0, 12'h010, 32'h0, 4'hf, rd, er);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		apb(1'b1, 12'h002, 32'h0000ffff, 4'hf, rd, er);
		chk("unaligned_err", {31'h0, er}, 32'h1);
		check_all();
		do_reset();
		give_verdict();
	end
endmodule
